// ### verification/fcd_decoder_sva.sv
/* fcd_decoder_sva.sv: port-level checks of the command decoder.
   Assumes it is bound onto fcd_decoder, one clock, async reset. */
`timescale 1ns/100ps
`include "fcd_consts.vh"
module fcd_decoder_sva (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire reg_select_line_i,
  input wire wr_strobe_i,
  input wire rd_strobe_i,
  input wire [7:0] wr_data_i,
  input wire exec_side0_end_i,
  input wire [7:0] rd_data_o,
  input wire exec_start_o,
  input wire [4:0] opcode_o,
  input wire multitrack_flag_o,
  input wire head_select_o,
  input wire [7:0] sector_o,
  input wire [7:0] cyl_o,
  input wire [7:0] fill_byte_o,
  input wire bad_command_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // a data register write, whatever the phase
  wire dw = wr_strobe_i & reg_select_line_i;
  function automatic bit fcd_known(input [4:0] o);
    return o inside {`FCD_OP_READ_DATA, `FCD_OP_READ_DEL,
      `FCD_OP_READ_TRACK, `FCD_OP_READ_ID, `FCD_OP_WRITE_DATA,
      `FCD_OP_WRITE_DEL, `FCD_OP_FORMAT};
  endfunction
  property p_start_pulse;
    exec_start_o |=> !exec_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse wider than one cycle");
  property p_start_cause;
    $rose(exec_start_o) |-> $past(dw) || $past(exec_side0_end_i);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without write or side end");
  property p_bad;
    $rose(bad_command_o) |-> $past(dw) && !fcd_known($past(wr_data_i[4:0]));
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad command flag without unknown opcode");
  property p_bad_clear;
    dw && fcd_known(wr_data_i[4:0]) && bad_command_o |=> !bad_command_o;
  endproperty
  a_bad_clear: assert property (p_bad_clear)
    else $error("bad command flag kept after good opcode");
  property p_op;
    $changed(opcode_o) |-> $past(dw) && fcd_known(opcode_o)
      && opcode_o == $past(wr_data_i[4:0]);
  endproperty
  a_op: assert property (p_op)
    else $error("opcode changed without matching write");
  property p_mt;
    $changed(opcode_o) && opcode_o != `FCD_OP_FORMAT
      |-> multitrack_flag_o == $past(wr_data_i[7]);
  endproperty
  a_mt: assert property (p_mt)
    else $error("multitrack flag not taken from bit 7");
  property p_mt_cont;
    exec_side0_end_i && multitrack_flag_o && !head_select_o
      |=> head_select_o && sector_o == 8'h01 && exec_start_o;
  endproperty
  a_mt_cont: assert property (p_mt_cont)
    else $error("no continuation on side 1 sector 1");
  property p_rd_hold;
    !rd_strobe_i |=> $stable(rd_data_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_field_hold;
    !wr_strobe_i && !exec_side0_end_i |=> $stable(cyl_o) && $stable(fill_byte_o);
  endproperty
  a_field_hold: assert property (p_field_hold)
    else $error("fields moved without a write");
  c_start: cover property (exec_start_o);
  c_bad: cover property ($rose(bad_command_o));
  c_mt: cover property (exec_side0_end_i && multitrack_flag_o);
endmodule // fcd_decoder_sva
bind fcd_decoder fcd_decoder_sva u_sva (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .reg_select_line_i(reg_select_line_i),
  .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i),
  .wr_data_i(wr_data_i), .exec_side0_end_i(exec_side0_end_i),
  .rd_data_o(rd_data_o), .exec_start_o(exec_start_o),
  .opcode_o(opcode_o), .multitrack_flag_o(multitrack_flag_o),
  .head_select_o(head_select_o), .sector_o(sector_o), .cyl_o(cyl_o),
  .fill_byte_o(fill_byte_o), .bad_command_o(bad_command_o));

// ### verification/fcd_host_model.sv
/* fcd_host_model.sv: host processor side, byte writes and reads.
   Assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/100ps
module fcd_host_model (
  input wire clk_sys_i,
  input wire [7:0] rd_data_i,
  output logic sel_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] data_o
);
  // idle bus from time zero
  initial begin
    sel_o = 1'b1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    data_o = 8'h00;
  end
  task put(input logic [7:0] d);
    @(negedge clk_sys_i);
    sel_o = 1'b1;
    wr_o = 1'b1;
    data_o = d;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    data_o = ~d; // released lines must not look valid
  endtask
  task get(input logic s, output logic [7:0] d);
    @(negedge clk_sys_i);
    sel_o = s;
    rd_o = 1'b1;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    d = rd_data_i;
  endtask
endmodule // fcd_host_model

// ### verification/tb.sv
/* tb.sv: self-checking bench of the command decoder.
   Assumes the host model drives the byte port and the bench plays
   the execution engine. */
`timescale 1ns/100ps
`include "fcd_consts.vh"
module tb;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg done = 1'b0;
  reg s0end = 1'b0;
  reg [7:0] res [0:6];
  wire sel, wr, rd, start, bad, mtrk, mfm, skip, head, dhi, dlo;
  wire [7:0] wdata, rdata;
  wire [4:0] opc;
  wire [7:0] fld [0:8];
  integer mismatches = 0, samples_checked = 0;
  integer i;
  localparam [34:0] ops = {`FCD_OP_READ_DATA, `FCD_OP_READ_DEL,
    `FCD_OP_READ_TRACK, `FCD_OP_READ_ID, `FCD_OP_WRITE_DATA,
    `FCD_OP_WRITE_DEL, `FCD_OP_FORMAT};
  // 250 MHz clock
  always #2 clk_sys_i = ~clk_sys_i;
  fcd_host_model u_host (.clk_sys_i(clk_sys_i), .rd_data_i(rdata),
    .sel_o(sel), .wr_o(wr), .rd_o(rd), .data_o(wdata));
  fcd_decoder dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_select_line_i(sel), .wr_strobe_i(wr), .rd_strobe_i(rd),
    .wr_data_i(wdata), .exec_done_i(done), .exec_side0_end_i(s0end),
    .result_status_0_i(res[0]), .result_status_1_i(res[1]),
    .result_status_2_i(res[2]), .res_cyl_i(res[3]),
    .res_head_i(res[4]), .res_sector_i(res[5]), .res_size_i(res[6]),
    .rd_data_o(rdata), .exec_start_o(start), .opcode_o(opc),
    .multitrack_flag_o(mtrk), .mfm_select_o(mfm),
    .skip_deleted_flag_o(skip), .head_select_o(head),
    .drive_sel_hi_o(dhi), .drive_sel_lo_o(dlo), .cyl_o(fld[0]),
    .head_addr_o(fld[1]), .sector_o(fld[2]), .size_code_o(fld[3]),
    .last_sector_of_track_o(fld[4]), .gap_len_o(fld[5]),
    .transfer_length_byte_o(fld[6]), .sectors_per_cyl_o(fld[7]),
    .fill_byte_o(fld[8]), .bad_command_o(bad));
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task conclude;
    $display("mismatches=%0d samples_checked=%0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one whole command: bytes, execution, status poll, seven results
  task run_cmd(input [7:0] b0, input [3:0] n, input [2:0] k);
    reg [7:0] b [0:8];
    reg [7:0] d;
    integer j;
    for (j = 0; j < 9; j++) begin
      b[j] = (j == 0) ? b0 : (j == 1) ? {5'h1f, k} : {k, 1'b0, 4'(j)};
      res[j % 7] = {k, 1'b1, 4'(j % 7)};
    end
    for (j = 0; j < n; j++) begin
      u_host.put(b[j]);
      chk_bit(start, j == n - 1);
    end
    chk_bit(bad, 1'b0);
    chk_byte({3'h0, opc}, {3'h0, b0[4:0]});
    chk_byte({5'h00, head, dhi, dlo}, {5'h00, k});
    chk_byte({5'h00, mtrk, mfm, skip}, {5'h00, b0[7:5]});
    if (n == 9)
      for (j = 2; j < 9; j++)
        chk_byte(fld[j - 2], b[j]);
    if (n == 6) begin
      chk_byte(fld[3], b[2]);
      chk_byte(fld[7], b[3]);
      chk_byte(fld[5], b[4]);
      chk_byte(fld[8], b[5]);
    end
    if (b0[7]) begin
      @(negedge clk_sys_i) s0end = 1'b1;
      @(negedge clk_sys_i) s0end = 1'b0;
      chk_byte({start, head, fld[2][5:0]}, 8'hc1);
    end
    @(negedge clk_sys_i) done = 1'b1;
    @(negedge clk_sys_i) done = 1'b0;
    u_host.put(8'h06);
    d = 8'h00;
    for (j = 0; j < 40 && !(d[7] && d[6]); j++)
      u_host.get(1'b0, d);
    chk_bit(d[7] & d[6], 1'b1);
    for (j = 0; j < 7; j++) begin
      u_host.get(1'b1, d);
      chk_byte(d, res[j]);
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(negedge clk_sys_i);
    chk_byte({start, bad, 6'h00}, 8'h00);
    chk_byte(rdata, 8'h00);
    rst_n_i = 1'b1;
    // the encoding bit toggles from command to command
    for (i = 0; i < 7; i++)
      run_cmd({1'b0, i[0], 1'b0, ops[34 - 5 * i -: 5]},
        (i == 3) ? 4'd2 : (i == 6) ? 4'd6 : 4'd9, 3'(i));
    u_host.put(8'h1f);
    chk_bit(bad, 1'b1);
    chk_byte({3'h0, opc}, {3'h0, `FCD_OP_FORMAT});
    run_cmd(8'he6, 4'd9, 3'd2);
    chk_byte({6'h00, mtrk, skip}, 8'h03);
    conclude;
  end
  // watchdog well beyond the expected run time
  initial begin
    #100000;
    mismatches++;
    conclude;
  end
endmodule // tb

// ### verilog/fcd_consts.vh
/*
 * fcd_consts.vh: constants of the diskette command decoder, covering
 * opcodes, command byte fields, sequence lengths, reset values and the
 * result fifo shape.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH

// opcodes, bits 4..0 of the first command byte
`define FCD_OP_READ_DATA 5'h06
`define FCD_OP_READ_DEL 5'h0c
`define FCD_OP_READ_TRACK 5'h02
`define FCD_OP_READ_ID 5'h0a
`define FCD_OP_WRITE_DATA 5'h05
`define FCD_OP_WRITE_DEL 5'h09
`define FCD_OP_FORMAT 5'h0d

// field positions in the first command byte
`define FCD_B0_MULTI_BIT 7
`define FCD_B0_MFM_BIT 6
`define FCD_B0_SKIP_BIT 5
`define FCD_B0_OP_MSB 4
// field positions in the second command byte
`define FCD_B1_HEAD_BIT 2
`define FCD_B1_DRIVE_MSB 1

// command sequence lengths in bytes
`define FCD_LEN_SECTOR 4'h9
`define FCD_LEN_READ_ID 4'h2
`define FCD_LEN_FORMAT 4'h6
// result sequence length in bytes
`define FCD_LEN_RESULT 4'h7

// fifo shape
`define FCD_FIFO_WIDTH 8
`define FCD_FIFO_DEPTH 8
`define FCD_FIFO_AW 3

// reset values
`define FCD_RST_BYTE 8'h00
`define FCD_RST_CNT 4'h0

`endif

// ### verilog/fcd_decoder.v
/*
 * fcd_decoder.v: command byte decoder of the diskette controller.
 * Takes command bytes on data register writes, decodes them, hands the
 * command to the execution engine, then queues seven result bytes in a
 * fifo that the host drains on data register reads.
 * Assumes inputs are synchronous to clk_sys_i and the execution engine
 * answers the last start pulse of each command with one done pulse and stable status.
 */
// Behaviour
// - recognise seven opcodes in bits 4..0 of the first command byte
// - don't-care bits, including byte 1 bits 7..3, never change behaviour
// - return status 0, 1, 2, cylinder, head, sector, size code
// - sector commands take nine bytes before execution starts
// - format takes six bytes, opcode byte bits 7 and 5 zero
// - multitrack finishing side 0 continues with sector 1 on side 1
// - every recognised command passes command, execution, then result phases; an unknown opcode stays in the command phase
// - select line low is main status, high is data register
`timescale 1ns/100ps
`include "fcd_consts.vh"

module fcd_decoder (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire reg_select_line_i,
  input wire wr_strobe_i,
  input wire rd_strobe_i,
  input wire [7:0] wr_data_i,
  input wire exec_done_i,
  input wire exec_side0_end_i,
  input wire [7:0] result_status_0_i,
  input wire [7:0] result_status_1_i,
  input wire [7:0] result_status_2_i,
  input wire [7:0] res_cyl_i,
  input wire [7:0] res_head_i,
  input wire [7:0] res_sector_i,
  input wire [7:0] res_size_i,
  output reg [7:0] rd_data_o,
  output reg exec_start_o,
  output reg [4:0] opcode_o,
  output reg multitrack_flag_o,
  output reg mfm_select_o,
  output reg skip_deleted_flag_o,
  output reg head_select_o,
  output reg drive_sel_hi_o,
  output reg drive_sel_lo_o,
  output reg [7:0] cyl_o,
  output reg [7:0] head_addr_o,
  output reg [7:0] sector_o,
  output reg [7:0] size_code_o,
  output reg [7:0] last_sector_of_track_o,
  output reg [7:0] gap_len_o,
  output reg [7:0] transfer_length_byte_o,
  output reg [7:0] sectors_per_cyl_o,
  output reg [7:0] fill_byte_o,
  output reg bad_command_o
);

  localparam ST_CMD = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_LOAD = 2'h2;
  localparam ST_RESULT = 2'h3;

  reg [1:0] state;
  reg [3:0] byte_cnt;
  reg [3:0] cmd_len;
  reg [3:0] res_cnt;
  reg is_format;
  reg [3:0] next_len;
  reg next_valid;
  reg [7:0] res_byte;
  wire data_wr;
  wire data_rd;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [7:0] main_status;
  wire fifo_in_valid;
  wire fifo_take;

  assign data_wr = wr_strobe_i && reg_select_line_i;
  assign data_rd = rd_strobe_i && reg_select_line_i;
  // main status: bit7 ready for access, bit6 direction to host, bit4 busy
  assign main_status = {(state == ST_CMD) || fifo_out_valid,
                        state == ST_RESULT, 1'b0, state != ST_CMD,
                        4'h0};
  assign fifo_in_valid = (state == ST_LOAD);
  assign fifo_take = data_rd && (state == ST_RESULT);

  always @* begin
    next_valid = 1'b1;
    next_len = `FCD_LEN_SECTOR;
    case (wr_data_i[`FCD_B0_OP_MSB:0])
      `FCD_OP_READ_DATA, `FCD_OP_READ_DEL, `FCD_OP_READ_TRACK,
      `FCD_OP_WRITE_DATA, `FCD_OP_WRITE_DEL: begin
        next_len = `FCD_LEN_SECTOR;
      end
      `FCD_OP_READ_ID: begin
        next_len = `FCD_LEN_READ_ID;
      end
      `FCD_OP_FORMAT: begin
        next_len = `FCD_LEN_FORMAT;
      end
      default: begin
        next_valid = 1'b0;
      end
    endcase
  end

  always @* begin
    case (res_cnt)
      4'h0: res_byte = result_status_0_i;
      4'h1: res_byte = result_status_1_i;
      4'h2: res_byte = result_status_2_i;
      4'h3: res_byte = res_cyl_i;
      4'h4: res_byte = res_head_i;
      4'h5: res_byte = res_sector_i;
      default: res_byte = res_size_i;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_CMD;
      byte_cnt <= `FCD_RST_CNT;
      cmd_len <= `FCD_RST_CNT;
      res_cnt <= `FCD_RST_CNT;
      is_format <= 1'b0;
      exec_start_o <= 1'b0;
      bad_command_o <= 1'b0;
      opcode_o <= 5'h00;
      multitrack_flag_o <= 1'b0;
      mfm_select_o <= 1'b0;
      skip_deleted_flag_o <= 1'b0;
      head_select_o <= 1'b0;
      drive_sel_hi_o <= 1'b0;
      drive_sel_lo_o <= 1'b0;
      cyl_o <= `FCD_RST_BYTE;
      head_addr_o <= `FCD_RST_BYTE;
      sector_o <= `FCD_RST_BYTE;
      size_code_o <= `FCD_RST_BYTE;
      last_sector_of_track_o <= `FCD_RST_BYTE;
      gap_len_o <= `FCD_RST_BYTE;
      transfer_length_byte_o <= `FCD_RST_BYTE;
      sectors_per_cyl_o <= `FCD_RST_BYTE;
      fill_byte_o <= `FCD_RST_BYTE;
    end else begin
      exec_start_o <= 1'b0;
      case (state)
        ST_CMD: begin
          // one command byte per data write
          if (data_wr) begin
            byte_cnt <= byte_cnt + 4'h1;
            if (byte_cnt == 4'h0) begin
              bad_command_o <= !next_valid;
              // an unknown opcode is dropped whole, old fields stay
              if (next_valid) begin
                cmd_len <= next_len;
                is_format <= (next_len == `FCD_LEN_FORMAT);
                opcode_o <= wr_data_i[`FCD_B0_OP_MSB:0];
                // format forces bits 7 and 5 to zero
                multitrack_flag_o <= wr_data_i[`FCD_B0_MULTI_BIT] &&
                                     (next_len != `FCD_LEN_FORMAT);
                mfm_select_o <= wr_data_i[`FCD_B0_MFM_BIT];
                skip_deleted_flag_o <= wr_data_i[`FCD_B0_SKIP_BIT] &&
                                       (next_len != `FCD_LEN_FORMAT);
              end else begin
                byte_cnt <= `FCD_RST_CNT;
              end
            end else if (byte_cnt == 4'h1) begin
              head_select_o <= wr_data_i[`FCD_B1_HEAD_BIT];
              drive_sel_hi_o <= wr_data_i[`FCD_B1_DRIVE_MSB];
              drive_sel_lo_o <= wr_data_i[0];
            end else if (is_format) begin
              case (byte_cnt)
                4'h2: size_code_o <= wr_data_i;
                4'h3: sectors_per_cyl_o <= wr_data_i;
                4'h4: gap_len_o <= wr_data_i;
                default: fill_byte_o <= wr_data_i;
              endcase
            end else begin
              case (byte_cnt)
                4'h2: cyl_o <= wr_data_i;
                4'h3: head_addr_o <= wr_data_i;
                4'h4: sector_o <= wr_data_i;
                4'h5: size_code_o <= wr_data_i;
                4'h6: last_sector_of_track_o <= wr_data_i;
                4'h7: gap_len_o <= wr_data_i;
                default: transfer_length_byte_o <= wr_data_i;
              endcase
            end
            // start only after the last byte
            if (byte_cnt == cmd_len - 4'h1 && byte_cnt != 4'h0) begin
              state <= ST_EXEC;
              exec_start_o <= 1'b1;
              byte_cnt <= `FCD_RST_CNT;
            end else if (byte_cnt == 4'h0 && next_valid &&
                         next_len == 4'h1) begin
              state <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          // side 0 done with multitrack, go on to side 1 sector 1
          if (exec_side0_end_i && multitrack_flag_o && !head_select_o) begin
            head_select_o <= 1'b1;
            head_addr_o <= 8'h01;
            sector_o <= 8'h01;
            exec_start_o <= 1'b1;
          end else if (exec_done_i) begin
            state <= ST_LOAD;
            res_cnt <= `FCD_RST_CNT;
          end
        end
        ST_LOAD: begin
          // stalls while the fifo is full
          if (fifo_in_ready) begin
            res_cnt <= res_cnt + 4'h1;
            if (res_cnt == `FCD_LEN_RESULT - 4'h1) begin
              state <= ST_RESULT;
              res_cnt <= `FCD_RST_CNT;
            end
          end
        end
        default: begin
          // back to idle after the seventh read
          if (fifo_take) begin
            res_cnt <= res_cnt + 4'h1;
            if (res_cnt == `FCD_LEN_RESULT - 4'h1) begin
              state <= ST_CMD;
              res_cnt <= `FCD_RST_CNT;
            end
          end
        end
      endcase
    end
  end

  // read data register, status or result byte
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `FCD_RST_BYTE;
    end else if (rd_strobe_i) begin
      rd_data_o <= reg_select_line_i ? fifo_out_data : main_status;
    end
  end

  // result bytes queue
  fcd_fifo #(
    .WIDTH(`FCD_FIFO_WIDTH),
    .DEPTH(`FCD_FIFO_DEPTH),
    .AW(`FCD_FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(res_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_out_data)
  );

endmodule // fcd_decoder

// ### verilog/fcd_fifo.v
/*
 * fcd_fifo.v: small synchronous fifo with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset; read data
 * comes from a register updated on each pop.
 */
`timescale 1ns/100ps
`include "fcd_consts.vh"

module fcd_fifo #(
  parameter WIDTH = `FCD_FIFO_WIDTH,
  parameter DEPTH = `FCD_FIFO_DEPTH,
  parameter AW = `FCD_FIFO_AW
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire stage_free;

  // output register refills when empty or being taken
  assign stage_free = !out_valid_o || out_ready_i;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign push = in_valid_i && in_ready_o;
  assign pop = stage_free && (count != {(AW+1){1'b0}});

  // storage array has no reset, it is only read behind count
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers, fill level and the registered head word
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data_o <= mem[rd_ptr];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // fcd_fifo
